// *** peak_detector_consts.svh ***
// Constants for the peak power and crossing detector
// Notes on behaviour
// - Peak flag sets when block peak rises above its upper threshold.
// - While enabled, flag clears only after peak stays below lower threshold whole delay.
// - Release delay is 16 bits, low and high byte, in clock cycles.
// - Select bit 0 feeds only the high comparator pair to the filter.
// - Select bit 1 feeds three-level minus one, zero, plus one value.
// - Crossing period is two to the power N, N in bits 3 to 0.
// - Crossing thresholds are 16-bit signed, 2 integer, 14 fraction bits.
// - Four crossing thresholds, low byte at lower address, high next.
// - Block peak spans programmed reduced samples, each peak of eight.
// - Enable bit turns detector on at 1, off at 0; 0 after reset.
// - Four hysteresis thresholds are 8-bit linear values, 256 full scale.
`ifndef PEAK_DETECTOR_CONSTS_SVH
`define PEAK_DETECTOR_CONSTS_SVH

`define IDX_ENABLE 8'h00
`define IDX_THR_UPPER_A 8'h07
`define IDX_THR_LOWER_A 8'h08
`define IDX_THR_UPPER_B 8'h09
`define IDX_THR_LOWER_B 8'h0a
`define IDX_DELAY_LOW 8'h0b
`define IDX_DELAY_HIGH 8'h0c
`define IDX_SELECT 8'h0d
`define IDX_PERIOD 8'h0e
`define IDX_F0_UPPER_LOW 8'h0f
`define IDX_F0_UPPER_HIGH 8'h10
`define IDX_F0_LOWER_LOW 8'h11
`define IDX_F0_LOWER_HIGH 8'h12
`define IDX_F1_UPPER_LOW 8'h16
`define IDX_F1_UPPER_HIGH 8'h17
`define IDX_F1_LOWER_LOW 8'h18
`define IDX_F1_LOWER_HIGH 8'h19
`define IDX_STATUS 8'h1f

`define BYTE_RESET 8'h00
`define WORD_RESET 16'h0000
`define ENABLE_BIT 0
`define SELECT_BIT 0
`define PERIOD_MSB 3
`define LANES 8
`define LANE_W 8
`define LENGTH_ONE 17'h00001
`define LEVEL_PLUS 2'sb01
`define LEVEL_ZERO 2'sb00
`define LEVEL_MINUS 2'sb11
`define APB_OK 1'b0
`define APB_ERR 1'b1

`endif

// *** peak_detector_pkg.sv ***
// Types for the peak power and crossing detector
package peak_detector_pkg;
  typedef logic [7:0] amp_t;
  typedef logic signed [1:0] level_t;
  typedef logic signed [15:0] frac_t;
  typedef enum logic {flag_clear, flag_set} hyst_state_t;
endpackage

// *** hyst_if.sv ***
// Carrier between the detector core and one hysteresis channel
`timescale 1ns/1ps
interface hyst_if;
  import peak_detector_pkg::*;
  amp_t peak;
  logic have_peak;
  amp_t upper;
  amp_t lower;
  logic [15:0] delay;
  logic enable;
  logic flag;
  modport core (output peak, have_peak, upper, lower, delay, enable,
    input flag);
  modport chan (input peak, have_peak, upper, lower, delay, enable,
    output flag);
endinterface

// *** peak_hysteresis.sv ***
// One peak hysteresis channel with release delay
`timescale 1ns/1ps
`include "peak_detector_consts.svh"
module peak_hysteresis
  import peak_detector_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  hyst_if.chan ch
);
  hyst_state_t state;
  hyst_state_t next_state;
  logic [15:0] count;
  logic [15:0] next_count;
  logic above;
  logic below;

  always_comb
  begin
    above = ch.have_peak && (ch.peak > ch.upper);
    below = ch.have_peak && (ch.peak < ch.lower);
    next_state = state;
    next_count = `WORD_RESET;
    if (!ch.enable)
    begin
      next_state = flag_clear;
    end
    else
    begin
      case (state)
        flag_clear:
        begin
          if (above)
          begin
            next_state = flag_set;
          end
        end
        flag_set:
        begin
          if (above || !below)
          begin
            next_count = `WORD_RESET;
          end
          else if (count >= ch.delay)
          begin
            next_state = flag_clear;
          end
          else
          begin
            next_count = count + 16'h0001;
          end
        end
        default:
        begin
          next_state = flag_clear;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= flag_clear;
      count <= `WORD_RESET;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign ch.flag = (state == flag_set);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_flag_sets: assert property (
    ch.enable && ch.have_peak && ch.peak > ch.upper |=> ch.flag)
    else $error("flag not set above upper threshold");
  a_flag_holds: assert property (
    ch.flag && ch.enable && !(ch.have_peak && ch.peak < ch.lower) |=> ch.flag)
    else $error("flag cleared while peak not below lower threshold");
  a_delay_waits: assert property (
    $fell(ch.flag) && $past(ch.enable) |-> $past(count) >= $past(ch.delay))
    else $error("flag cleared before release delay elapsed");
endmodule

// *** peak_detector.sv ***
// Peak power and crossing detector core with APB register file
`timescale 1ns/1ps
`include "peak_detector_consts.svh"
module peak_detector
  import peak_detector_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [63:0] sample_lanes,
  input wire logic [16:0] peak_block_length,
  output logic peak_flag_a,
  output logic peak_flag_b,
  output level_t iir_input,
  output logic crossing_tick,
  output frac_t filter0_upper_thr,
  output frac_t filter0_lower_thr,
  output frac_t filter1_upper_thr,
  output frac_t filter1_lower_thr,
  output amp_t block_peak
);
  // Register file
  logic peak_detector_enable;
  amp_t peak_upper_thr_a;
  amp_t peak_lower_thr_a;
  amp_t peak_upper_thr_b;
  amp_t peak_lower_thr_b;
  logic [15:0] release_delay_count;
  logic filter_input_select;
  logic [3:0] crossing_period_exponent;
  frac_t f0_upper;
  frac_t f0_lower;
  frac_t f1_upper;
  frac_t f1_lower;
  logic next_enable;
  amp_t next_upper_a;
  amp_t next_lower_a;
  amp_t next_upper_b;
  amp_t next_lower_b;
  logic [15:0] next_delay;
  logic next_select;
  logic [3:0] next_exponent;
  frac_t next_f0_upper;
  frac_t next_f0_lower;
  frac_t next_f1_upper;
  frac_t next_f1_lower;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [7:0] index;
  logic do_write;
  logic hit;
  logic [7:0] rd_byte;
  logic [7:0] wb;

  // Peak path
  amp_t reduced;
  amp_t run_max;
  amp_t next_run_max;
  logic [16:0] blk_cnt;
  logic [16:0] next_blk_cnt;
  amp_t next_block_peak;
  logic have_peak;
  logic next_have_peak;
  logic blk_end;
  level_t next_iir;
  logic [15:0] per_cnt;
  logic [15:0] next_per_cnt;
  logic [15:0] per_limit;
  logic next_tick;
  logic next_flag_a;
  logic next_flag_b;

  hyst_if ha();
  hyst_if hb();

  // APB access: one wait state, write and read at the pready edge
  always_comb
  begin
    index = {2'b00, paddr[7:2]};
    wb = pwdata[7:0];
    hit = 1'b1;
    rd_byte = `BYTE_RESET;
    case (index)
      `IDX_ENABLE: rd_byte = {7'h00, peak_detector_enable};
      `IDX_THR_UPPER_A: rd_byte = peak_upper_thr_a;
      `IDX_THR_LOWER_A: rd_byte = peak_lower_thr_a;
      `IDX_THR_UPPER_B: rd_byte = peak_upper_thr_b;
      `IDX_THR_LOWER_B: rd_byte = peak_lower_thr_b;
      `IDX_DELAY_LOW: rd_byte = release_delay_count[7:0];
      `IDX_DELAY_HIGH: rd_byte = release_delay_count[15:8];
      `IDX_SELECT: rd_byte = {7'h00, filter_input_select};
      `IDX_PERIOD: rd_byte = {4'h0, crossing_period_exponent};
      `IDX_F0_UPPER_LOW: rd_byte = f0_upper[7:0];
      `IDX_F0_UPPER_HIGH: rd_byte = f0_upper[15:8];
      `IDX_F0_LOWER_LOW: rd_byte = f0_lower[7:0];
      `IDX_F0_LOWER_HIGH: rd_byte = f0_lower[15:8];
      `IDX_F1_UPPER_LOW: rd_byte = f1_upper[7:0];
      `IDX_F1_UPPER_HIGH: rd_byte = f1_upper[15:8];
      `IDX_F1_LOWER_LOW: rd_byte = f1_lower[7:0];
      `IDX_F1_LOWER_HIGH: rd_byte = f1_lower[15:8];
      `IDX_STATUS: rd_byte = {6'h00, peak_flag_b, peak_flag_a};
      default: hit = 1'b0;
    endcase
    do_write = psel && penable && pready && pwrite && hit;
    next_pready = psel && penable && !pready;
    next_pslverr = next_pready ? !hit : `APB_OK;
    next_prdata = (next_pready && !pwrite) ? {24'h000000, rd_byte}
      : 32'h00000000;
  end

  // Register writes; unused upper bits are dropped
  always_comb
  begin
    next_enable = peak_detector_enable;
    next_upper_a = peak_upper_thr_a;
    next_lower_a = peak_lower_thr_a;
    next_upper_b = peak_upper_thr_b;
    next_lower_b = peak_lower_thr_b;
    next_delay = release_delay_count;
    next_select = filter_input_select;
    next_exponent = crossing_period_exponent;
    next_f0_upper = f0_upper;
    next_f0_lower = f0_lower;
    next_f1_upper = f1_upper;
    next_f1_lower = f1_lower;
    if (do_write)
    begin
      case (index)
        `IDX_ENABLE: next_enable = wb[`ENABLE_BIT];
        `IDX_THR_UPPER_A: next_upper_a = wb;
        `IDX_THR_LOWER_A: next_lower_a = wb;
        `IDX_THR_UPPER_B: next_upper_b = wb;
        `IDX_THR_LOWER_B: next_lower_b = wb;
        `IDX_DELAY_LOW: next_delay[7:0] = wb;
        `IDX_DELAY_HIGH: next_delay[15:8] = wb;
        `IDX_SELECT: next_select = wb[`SELECT_BIT];
        `IDX_PERIOD: next_exponent = wb[`PERIOD_MSB:0];
        `IDX_F0_UPPER_LOW: next_f0_upper[7:0] = wb;
        `IDX_F0_UPPER_HIGH: next_f0_upper[15:8] = wb;
        `IDX_F0_LOWER_LOW: next_f0_lower[7:0] = wb;
        `IDX_F0_LOWER_HIGH: next_f0_lower[15:8] = wb;
        `IDX_F1_UPPER_LOW: next_f1_upper[7:0] = wb;
        `IDX_F1_UPPER_HIGH: next_f1_upper[15:8] = wb;
        `IDX_F1_LOWER_LOW: next_f1_lower[7:0] = wb;
        `IDX_F1_LOWER_HIGH: next_f1_lower[15:8] = wb;
        default: next_enable = peak_detector_enable;
      endcase
    end
  end

  // Block peak over the programmed number of reduced samples
  always_comb
  begin
    reduced = sample_lanes[`LANE_W-1:0];
    for (int i = 1; i < `LANES; i++)
    begin
      if (sample_lanes[i*`LANE_W +: `LANE_W] > reduced)
      begin
        reduced = sample_lanes[i*`LANE_W +: `LANE_W];
      end
    end
    blk_end = (blk_cnt + `LENGTH_ONE) >= peak_block_length;
    next_run_max = (reduced > run_max) ? reduced : run_max;
    next_blk_cnt = blk_cnt + `LENGTH_ONE;
    next_block_peak = block_peak;
    next_have_peak = have_peak;
    if (!peak_detector_enable)
    begin
      next_run_max = `BYTE_RESET;
      next_blk_cnt = 17'h00000;
      next_have_peak = 1'b0;
    end
    else if (blk_end)
    begin
      next_block_peak = next_run_max;
      next_run_max = `BYTE_RESET;
      next_blk_cnt = 17'h00000;
      next_have_peak = 1'b1;
    end
  end

  // Filter input level and crossing period tick
  always_comb
  begin
    next_flag_a = ha.flag;
    next_flag_b = hb.flag;
    if (!filter_input_select)
    begin
      next_iir = ha.flag ? `LEVEL_PLUS : `LEVEL_ZERO;
    end
    else if (ha.flag)
    begin
      next_iir = `LEVEL_PLUS;
    end
    else
    begin
      next_iir = hb.flag ? `LEVEL_ZERO : `LEVEL_MINUS;
    end
    per_limit = (16'h0001 << crossing_period_exponent) - 16'h0001;
    next_tick = 1'b0;
    next_per_cnt = per_cnt + 16'h0001;
    if (!peak_detector_enable)
    begin
      next_per_cnt = `WORD_RESET;
      next_iir = `LEVEL_ZERO;
    end
    else if (per_cnt >= per_limit)
    begin
      next_per_cnt = `WORD_RESET;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      peak_detector_enable <= 1'b0;
      peak_upper_thr_a <= `BYTE_RESET;
      peak_lower_thr_a <= `BYTE_RESET;
      peak_upper_thr_b <= `BYTE_RESET;
      peak_lower_thr_b <= `BYTE_RESET;
      release_delay_count <= `WORD_RESET;
      filter_input_select <= 1'b0;
      crossing_period_exponent <= 4'h0;
      f0_upper <= `WORD_RESET;
      f0_lower <= `WORD_RESET;
      f1_upper <= `WORD_RESET;
      f1_lower <= `WORD_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= `APB_OK;
      run_max <= `BYTE_RESET;
      blk_cnt <= 17'h00000;
      block_peak <= `BYTE_RESET;
      have_peak <= 1'b0;
      iir_input <= `LEVEL_ZERO;
      per_cnt <= `WORD_RESET;
      crossing_tick <= 1'b0;
      peak_flag_a <= 1'b0;
      peak_flag_b <= 1'b0;
      filter0_upper_thr <= `WORD_RESET;
      filter0_lower_thr <= `WORD_RESET;
      filter1_upper_thr <= `WORD_RESET;
      filter1_lower_thr <= `WORD_RESET;
    end
    else
    begin
      peak_detector_enable <= next_enable;
      peak_upper_thr_a <= next_upper_a;
      peak_lower_thr_a <= next_lower_a;
      peak_upper_thr_b <= next_upper_b;
      peak_lower_thr_b <= next_lower_b;
      release_delay_count <= next_delay;
      filter_input_select <= next_select;
      crossing_period_exponent <= next_exponent;
      f0_upper <= next_f0_upper;
      f0_lower <= next_f0_lower;
      f1_upper <= next_f1_upper;
      f1_lower <= next_f1_lower;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      run_max <= next_run_max;
      blk_cnt <= next_blk_cnt;
      block_peak <= next_block_peak;
      have_peak <= next_have_peak;
      iir_input <= next_iir;
      per_cnt <= next_per_cnt;
      crossing_tick <= next_tick;
      peak_flag_a <= next_flag_a;
      peak_flag_b <= next_flag_b;
      filter0_upper_thr <= f0_upper;
      filter0_lower_thr <= f0_lower;
      filter1_upper_thr <= f1_upper;
      filter1_lower_thr <= f1_lower;
    end
  end

  // Hysteresis channels: pair a drives the high, pair b the low comparators
  assign ha.peak = block_peak;
  assign ha.have_peak = have_peak;
  assign ha.upper = peak_upper_thr_a;
  assign ha.lower = peak_lower_thr_a;
  assign ha.delay = release_delay_count;
  assign ha.enable = peak_detector_enable;
  assign hb.peak = block_peak;
  assign hb.have_peak = have_peak;
  assign hb.upper = peak_upper_thr_b;
  assign hb.lower = peak_lower_thr_b;
  assign hb.delay = release_delay_count;
  assign hb.enable = peak_detector_enable;

  peak_hysteresis u_chan_a (
    .clk(clk),
    .rst(rst),
    .ch(ha.chan)
  );

  peak_hysteresis u_chan_b (
    .clk(clk),
    .rst(rst),
    .ch(hb.chan)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_select_high: assert property (
    peak_detector_enable && !filter_input_select
    |=> iir_input == ($past(ha.flag) ? `LEVEL_PLUS : `LEVEL_ZERO))
    else $error("two-level filter input wrong");
  a_select_three: assert property (
    peak_detector_enable && filter_input_select && !ha.flag && !hb.flag
    |=> iir_input == `LEVEL_MINUS)
    else $error("three-level filter input not minus one");
  a_period_spacing: assert property (
    crossing_tick && crossing_period_exponent == 4'h2 && peak_detector_enable
    ##1 (crossing_period_exponent == 4'h2 && peak_detector_enable) [*4]
    |-> crossing_tick && !$past(crossing_tick) && !$past(crossing_tick, 2)
    && !$past(crossing_tick, 3))
    else $error("crossing period not four cycles");
  a_thr_follow: assert property (
    ##1 filter0_upper_thr == $past(f0_upper))
    else $error("filter threshold output stale");
  a_thr_bytes: assert property (
    do_write && index == `IDX_F1_LOWER_HIGH
    |=> f1_lower[15:8] == $past(pwdata[7:0]))
    else $error("threshold high byte not stored");
  a_reduced_max: assert property (
    peak_detector_enable && blk_end |=> block_peak >= $past(reduced))
    else $error("block peak below reduced sample");
  a_disable_clear: assert property (
    !peak_detector_enable |-> ##2 !peak_flag_a && !peak_flag_b)
    else $error("flags set while disabled");
  a_no_peak_idle: assert property (
    !have_peak |=> !ha.flag && !hb.flag)
    else $error("flag set before any block peak");
  a_apb_answer: assert property (
    psel && penable && !pready |=> pready)
    else $error("apb answer late");
endmodule

// *** agc_monitor.sv ***
// Gain control model that counts alarm flag rises
`timescale 1ns/1ps
module agc_monitor
(
  input wire logic clk,
  input wire logic rst,
  input wire logic peak_flag_a,
  input wire logic peak_flag_b,
  output int rises_a,
  output int rises_b
);
  logic last_a;
  logic last_b;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      last_a <= 1'b0;
      last_b <= 1'b0;
      rises_a <= 0;
      rises_b <= 0;
    end
    else
    begin
      last_a <= peak_flag_a;
      last_b <= peak_flag_b;
      if (peak_flag_a === 1'b1 && last_a === 1'b0)
        rises_a <= rises_a + 1;
      if (peak_flag_b === 1'b1 && last_b === 1'b0)
        rises_b <= rises_b + 1;
    end
  end
endmodule

// *** tb_peak_detector.sv ***
// Testbench for the peak power and crossing detector
`timescale 1ns/1ps
`include "peak_detector_consts.svh"
`define CHECK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("Error at %0t got %h exp %h", $time, got, exp); \
    end \
  end
module tb_peak_detector;
  import peak_detector_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [63:0] sample_lanes;
  logic [16:0] peak_block_length;
  logic peak_flag_a, peak_flag_b, crossing_tick;
  level_t iir_input;
  frac_t f0u, f0l, f1u, f1l;
  amp_t block_peak;
  int err_count = 0;
  int n_tests = 0;
  int rises_a, rises_b, gap;
  logic [7:0] rw_idx [16] = '{`IDX_THR_UPPER_A, `IDX_THR_LOWER_A,
    `IDX_THR_UPPER_B, `IDX_THR_LOWER_B, `IDX_DELAY_LOW, `IDX_DELAY_HIGH,
    `IDX_F0_UPPER_LOW, `IDX_F0_UPPER_HIGH, `IDX_F0_LOWER_LOW,
    `IDX_F0_LOWER_HIGH, `IDX_F1_UPPER_LOW, `IDX_F1_UPPER_HIGH,
    `IDX_F1_LOWER_LOW, `IDX_F1_LOWER_HIGH, `IDX_SELECT, `IDX_PERIOD};
  peak_detector dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_lanes(sample_lanes), .peak_block_length(peak_block_length),
    .peak_flag_a(peak_flag_a), .peak_flag_b(peak_flag_b),
    .iir_input(iir_input), .crossing_tick(crossing_tick),
    .filter0_upper_thr(f0u), .filter0_lower_thr(f0l),
    .filter1_upper_thr(f1u), .filter1_lower_thr(f1l),
    .block_peak(block_peak));
  agc_monitor agc (.clk(clk), .rst(rst), .peak_flag_a(peak_flag_a),
    .peak_flag_b(peak_flag_b), .rises_a(rises_a), .rises_b(rises_b));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] idx,
    input logic [7:0] d, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'hffffff, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      err_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, d, rd, err);
    `CHECK(err, 1'b0)
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp,
    input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 8'h00, rd, err);
    `CHECK(rd, exp)
    `CHECK(err, exp_err)
  endtask
  // Holds one lane at v, the rest at 1, for n cycles
  task automatic drive(input logic [7:0] v, input int lane, input int n);
    logic [63:0] s;
    s = {8{8'h01}};
    s[lane*8 +: 8] = v;
    sample_lanes <= s;
    repeat (n) @(posedge clk);
  endtask
  task automatic tick_gap(output int g);
    int n;
    n = 0;
    while (crossing_tick !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    g = 1;
    while (crossing_tick !== 1'b1 && g < 300)
    begin
      @(posedge clk);
      g++;
    end
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    sample_lanes = 64'h0;
    peak_block_length = 17'h00001;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    `CHECK({peak_flag_a, peak_flag_b}, 2'b00)
    rd_chk(`IDX_ENABLE, 32'h0, 1'b0);
    rd_chk(`IDX_STATUS, 32'h0, 1'b0);
    rd_chk(8'h05, 32'h0, 1'b1);
    for (int i = 0; i < 16; i++)
      rd_chk(rw_idx[i], 32'h0, 1'b0);
    for (int i = 0; i < 14; i++)
      wr(rw_idx[i], rw_idx[i] ^ 8'ha5);
    for (int i = 0; i < 14; i++)
      rd_chk(rw_idx[i], {24'h0, rw_idx[i] ^ 8'ha5}, 1'b0);
    wr(`IDX_SELECT, 8'h01);
    wr(`IDX_PERIOD, 8'h0f);
    rd_chk(`IDX_SELECT, 32'h01, 1'b0);
    rd_chk(`IDX_PERIOD, 32'h0f, 1'b0);
    wr(`IDX_F0_UPPER_LOW, 8'h00);
    wr(`IDX_F0_UPPER_HIGH, 8'h40);
    wr(`IDX_F0_LOWER_LOW, 8'h00);
    wr(`IDX_F0_LOWER_HIGH, 8'h08);
    wr(`IDX_F1_LOWER_LOW, 8'h00);
    wr(`IDX_F1_LOWER_HIGH, 8'hc0);
    repeat (2) @(posedge clk);
    `CHECK(f0u, 16'sh4000)
    `CHECK(f0l, 16'sh0800)
    `CHECK(f1u, {8'h17 ^ 8'ha5, 8'h16 ^ 8'ha5})
    `CHECK(f1l, 16'shc000)
    wr(`IDX_THR_UPPER_A, 8'd100);
    wr(`IDX_THR_LOWER_A, 8'd80);
    wr(`IDX_THR_UPPER_B, 8'd50);
    wr(`IDX_THR_LOWER_B, 8'd30);
    wr(`IDX_DELAY_LOW, 8'h00);
    wr(`IDX_DELAY_HIGH, 8'h01);
    wr(`IDX_SELECT, 8'h01);
    wr(`IDX_ENABLE, 8'h01);
    drive(8'd100, 6, 8);
    `CHECK({peak_flag_a, peak_flag_b}, 2'b01)
    `CHECK(iir_input, 2'sb00)
    drive(8'd120, 3, 8);
    `CHECK(block_peak, 8'd120)
    `CHECK(peak_flag_a, 1'b1)
    `CHECK(iir_input, 2'sb01)
    rd_chk(`IDX_STATUS, 32'h03, 1'b0);
    wr(`IDX_SELECT, 8'h00);
    drive(8'd120, 3, 3);
    `CHECK(iir_input, 2'sb01)
    wr(`IDX_SELECT, 8'h01);
    drive(8'd60, 1, 250);
    `CHECK(peak_flag_a, 1'b1)
    drive(8'd90, 1, 2);
    drive(8'd60, 1, 200);
    `CHECK(peak_flag_a, 1'b1)
    drive(8'd60, 1, 70);
    `CHECK({peak_flag_a, peak_flag_b}, 2'b01)
    `CHECK(iir_input, 2'sb00)
    `CHECK(rises_a, 1)
    wr(`IDX_SELECT, 8'h00);
    drive(8'd10, 0, 270);
    `CHECK(peak_flag_b, 1'b0)
    `CHECK(iir_input, 2'sb00)
    wr(`IDX_SELECT, 8'h01);
    drive(8'd10, 0, 3);
    `CHECK(iir_input, 2'sb11)
    wr(`IDX_DELAY_HIGH, 8'h00);
    foreach (rw_idx[i])
      if (i < 4)
      begin
        wr(`IDX_PERIOD, 8'(i * 2 + i / 2));
        tick_gap(gap);
        tick_gap(gap);
        `CHECK(gap, 1 << (i * 2 + i / 2))
      end
    peak_block_length <= 17'h00004;
    for (int r = 0; r < 3; r++)
    begin
      drive(8'd40, 0, 1);
      drive(8'd70, 5, 1);
      drive(8'd20, 7, 1);
      drive(8'd30, 2, 1);
    end
    `CHECK(block_peak, 8'd70)
    drive(8'd20, 4, 12);
    `CHECK(block_peak, 8'd20)
    drive(8'd200, 2, 12);
    `CHECK(rises_a, 2)
    `CHECK(rises_b, 3)
    wr(`IDX_ENABLE, 8'h00);
    repeat (3) @(posedge clk);
    `CHECK({peak_flag_a, peak_flag_b}, 2'b00)
    rd_chk(`IDX_STATUS, 32'h0, 1'b0);
    print_verdict();
  end
endmodule
